//--- src/c22_regs.sv
// Functional notes
// - unsupported technology ability bits read zero
// - 10 Mbps full duplex ability reads one
// - extended status support reads zero
// - unidirectional ability reads zero
// - no preamble suppression; station sends preamble
// - autoneg complete is internal done flag anded with link state
// - remote fault always reads zero
// - autoneg ability mirrors internal ability flag
// - link status latches low until read
// - jabber detect always reads zero
// - extended capability always reads one
// - identifier high is read-only sixteen bits
// - identifier low holds oui, model, revision
// - function field selects data register meaning
// - device field routes indirect accesses
// - data register at 0xe reaches device space
`timescale 1ns/1ps
`default_nettype none

module c22_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register access from the management frame engine
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  // internal status from the autonegotiation logic
  input  wire logic        autoneg_done_internal,
  input  wire logic        autoneg_ability_internal,
  input  wire logic        link_state_internal,
  // indirect data port towards the device register space
  output logic      [4:0]  mmd_dev,
  output logic      [15:0] mmd_addr,
  output logic             mmd_wr,
  output logic             mmd_rd,
  output logic      [15:0] mmd_wdata,
  input  wire logic [15:0] mmd_rdata
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0][15:0] held_addr;
    logic [1:0]        func;
    logic [4:0]        devsel;
    logic              link_latch;
    logic              rd_pend;
    logic              pend_mmd;
    logic [15:0]       pend_data;
    logic [15:0]       rdata;
    logic              rvalid;
    logic              mmd_wr;
    logic              mmd_rd;
    logic [4:0]        mmd_dev;
    logic [15:0]       mmd_addr;
    logic [15:0]       mmd_wdata;
  } c22_state_type;

  c22_state_type st_q;
  c22_state_type st_d;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] next_addr(input logic [15:0] a);
    next_addr = a + 16'h0001;
  endfunction

  function automatic logic is_data_func(input logic [1:0] f);
    is_data_func = (f != c22_pkg::FUNC_ADDRESS);
  endfunction

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  logic [15:0] status_word;
  logic [15:0] ctrl_word;
  logic [15:0] id_low_word;

  always_comb begin
    status_word = 16'h0000;
    status_word[c22_pkg::T4_ABILITY_BIT]      = 1'b0;
    status_word[c22_pkg::FD100X_ABILITY_BIT]  = 1'b0;
    status_word[c22_pkg::HD100X_ABILITY_BIT]  = 1'b0;
    status_word[c22_pkg::FD10_ABILITY_BIT]    = 1'b1;
    status_word[c22_pkg::HD10_ABILITY_BIT]    = 1'b0;
    status_word[c22_pkg::FD_T2_ABILITY_BIT]   = 1'b0;
    status_word[c22_pkg::HD_T2_ABILITY_BIT]   = 1'b0;
    status_word[c22_pkg::EXT_STATUS_BIT]      = 1'b0;
    status_word[c22_pkg::UNIDIR_ABILITY_BIT]  = 1'b0;
    // frames without preamble are not accepted upstream
    status_word[c22_pkg::PREAMBLE_SUPP_BIT]   = 1'b0;
    status_word[c22_pkg::AUTONEG_DONE_BIT]    =
      autoneg_done_internal & link_state_internal;
    status_word[c22_pkg::REMOTE_FAULT_BIT]    = 1'b0;
    status_word[c22_pkg::AUTONEG_ABILITY_BIT] =
      autoneg_ability_internal;
    // a fail in the read cycle itself is reported, not lost
    status_word[c22_pkg::LINK_UP_BIT]         =
      st_q.link_latch & link_state_internal;
    status_word[c22_pkg::JABBER_BIT]          = 1'b0;
    status_word[c22_pkg::EXT_CAPABILITY_BIT]  = 1'b1;
  end

  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[c22_pkg::FUNC_MSB:c22_pkg::FUNC_LSB] = st_q.func;
    ctrl_word[c22_pkg::DEV_MSB:c22_pkg::DEV_LSB]   = st_q.devsel;
  end

  assign id_low_word = {c22_pkg::ID_LOW_OUI, c22_pkg::ID_MODEL,
                        c22_pkg::ID_REVISION};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic        rd_take;
  logic        ind_data_rd;
  logic [15:0] cur_addr;

  assign rd_take  = reg_rd & ~reg_wr;
  assign cur_addr = st_q.held_addr[st_q.devsel];
  assign ind_data_rd = rd_take & (reg_addr == c22_pkg::ADDR_IND_DATA)
                       & is_data_func(st_q.func);

  always_comb begin
    st_d        = st_q;
    st_d.mmd_wr = 1'b0;
    st_d.mmd_rd = 1'b0;
    st_d.rvalid = 1'b0;

    // latch-low link: fail sticks until status is read
    if (rd_take && reg_addr == c22_pkg::ADDR_STATUS) begin
      st_d.link_latch = link_state_internal;
    end else begin
      st_d.link_latch = st_q.link_latch & link_state_internal;
    end

    // writes; a write in the same cycle as a read wins
    if (reg_wr) begin
      if (reg_addr == c22_pkg::ADDR_IND_CTRL) begin
        st_d.func   =
          reg_wdata[c22_pkg::FUNC_MSB:c22_pkg::FUNC_LSB];
        st_d.devsel =
          reg_wdata[c22_pkg::DEV_MSB:c22_pkg::DEV_LSB];
      end else if (reg_addr == c22_pkg::ADDR_IND_DATA) begin
        if (!is_data_func(st_q.func)) begin
          st_d.held_addr[st_q.devsel] = reg_wdata;
        end else begin
          st_d.mmd_wr    = 1'b1;
          st_d.mmd_dev   = st_q.devsel;
          st_d.mmd_addr  = cur_addr;
          st_d.mmd_wdata = reg_wdata;
          if (st_q.func == c22_pkg::FUNC_DATA_INC ||
              st_q.func == c22_pkg::FUNC_DATA_INC_W) begin
            st_d.held_addr[st_q.devsel] = next_addr(cur_addr);
          end
        end
      end
    end

    // read stage one: capture local value or launch device read
    st_d.rd_pend  = rd_take;
    st_d.pend_mmd = ind_data_rd;
    if (rd_take) begin
      if (reg_addr == c22_pkg::ADDR_STATUS) begin
        st_d.pend_data = status_word;
      end else if (reg_addr == c22_pkg::ADDR_ID_HIGH) begin
        st_d.pend_data = c22_pkg::ID_HIGH_VALUE;
      end else if (reg_addr == c22_pkg::ADDR_ID_LOW) begin
        st_d.pend_data = id_low_word;
      end else if (reg_addr == c22_pkg::ADDR_IND_CTRL) begin
        st_d.pend_data = ctrl_word;
      end else if (reg_addr == c22_pkg::ADDR_IND_DATA) begin
        st_d.pend_data = cur_addr;
      end else begin
        st_d.pend_data = 16'h0000;
      end
    end
    if (ind_data_rd) begin
      st_d.mmd_rd   = 1'b1;
      st_d.mmd_dev  = st_q.devsel;
      st_d.mmd_addr = cur_addr;
      if (st_q.func == c22_pkg::FUNC_DATA_INC) begin
        st_d.held_addr[st_q.devsel] = next_addr(cur_addr);
      end
    end

    // read stage two: answer
    if (st_q.rd_pend) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = st_q.pend_mmd ? mmd_rdata : st_q.pend_data;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
      // function and device reset per control reset value
      st_q.func <=
        c22_pkg::IND_CTRL_RESET[c22_pkg::FUNC_MSB:c22_pkg::FUNC_LSB];
      st_q.devsel <=
        c22_pkg::IND_CTRL_RESET[c22_pkg::DEV_MSB:c22_pkg::DEV_LSB];
      st_q.rdata <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata  = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign mmd_dev    = st_q.mmd_dev;
  assign mmd_addr   = st_q.mmd_addr;
  assign mmd_wr     = st_q.mmd_wr;
  assign mmd_rd     = st_q.mmd_rd;
  assign mmd_wdata  = st_q.mmd_wdata;

endmodule

`default_nettype wire

//--- src/c22_pkg.sv
package c22_pkg;

  // ---------------------------------------------------------------
  // register addresses on the management interface
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_STATUS   = 5'h01;
  localparam logic [4:0] ADDR_ID_HIGH  = 5'h02;
  localparam logic [4:0] ADDR_ID_LOW   = 5'h03;
  localparam logic [4:0] ADDR_IND_CTRL = 5'h0d;
  localparam logic [4:0] ADDR_IND_DATA = 5'h0e;

  // ---------------------------------------------------------------
  // status register bit positions
  // ---------------------------------------------------------------
  localparam int T4_ABILITY_BIT         = 15;
  localparam int FD100X_ABILITY_BIT     = 14;
  localparam int HD100X_ABILITY_BIT     = 13;
  localparam int FD10_ABILITY_BIT       = 12;
  localparam int HD10_ABILITY_BIT       = 11;
  localparam int FD_T2_ABILITY_BIT      = 10;
  localparam int HD_T2_ABILITY_BIT      = 9;
  localparam int EXT_STATUS_BIT         = 8;
  localparam int UNIDIR_ABILITY_BIT     = 7;
  localparam int PREAMBLE_SUPP_BIT      = 6;
  localparam int AUTONEG_DONE_BIT       = 5;
  localparam int REMOTE_FAULT_BIT       = 4;
  localparam int AUTONEG_ABILITY_BIT    = 3;
  localparam int LINK_UP_BIT            = 2;
  localparam int JABBER_BIT             = 1;
  localparam int EXT_CAPABILITY_BIT     = 0;
  localparam logic [15:0] STATUS_RESET  = 16'h1009;

  // ---------------------------------------------------------------
  // identifier fields (values arbitrary, not a real maker code)
  // ---------------------------------------------------------------
  localparam logic [15:0] ID_HIGH_VALUE  = 16'h5a5a;
  localparam logic [5:0]  ID_LOW_OUI     = 6'h15;
  localparam logic [5:0]  ID_MODEL       = 6'h2a;
  localparam logic [3:0]  ID_REVISION    = 4'h3;

  // ---------------------------------------------------------------
  // indirect access control layout and functions
  // ---------------------------------------------------------------
  localparam int FUNC_MSB = 15;
  localparam int FUNC_LSB = 14;
  localparam int DEV_MSB  = 4;
  localparam int DEV_LSB  = 0;
  localparam logic [15:0] IND_CTRL_RESET = 16'h0000;

  typedef enum logic [1:0] {
    FUNC_ADDRESS    = 2'b00,
    FUNC_DATA       = 2'b01,
    FUNC_DATA_INC   = 2'b10,
    FUNC_DATA_INC_W = 2'b11
  } c22_func_type;

endpackage

//--- test/c22_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module c22_regs_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register port
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  // status inputs
  input wire logic        autoneg_done_internal,
  input wire logic        autoneg_ability_internal,
  input wire logic        link_state_internal,
  // indirect port
  input wire logic [4:0]  mmd_dev,
  input wire logic [15:0] mmd_addr,
  input wire logic        mmd_wr,
  input wire logic        mmd_rd,
  input wire logic [15:0] mmd_wdata,
  input wire logic [15:0] mmd_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] ctl_q;
  logic        rd_st;
  logic        rd_ie;
  // shadow of the control word, so indirect checks know the function
  always_ff @(posedge clk) begin
    if (!rst_n)
      ctl_q <= 16'h0000;
    else if (reg_wr && reg_addr == 5'h0d)
      ctl_q <= reg_wdata;
  end
  assign rd_st = reg_rd && !reg_wr && reg_addr == 5'h01;
  assign rd_ie = reg_rd && !reg_wr && reg_addr == 5'h0e;
  id_high_a: assert property (
    reg_rd && !reg_wr && reg_addr == 5'h02 |-> ##2 reg_rvalid
    && reg_rdata == c22_pkg::ID_HIGH_VALUE) else $error("id high bad");
  id_low_a: assert property (
    reg_rd && !reg_wr && reg_addr == 5'h03 |-> ##2 reg_rvalid
    && reg_rdata == {c22_pkg::ID_LOW_OUI, c22_pkg::ID_MODEL,
    c22_pkg::ID_REVISION}) else $error("id low");
  zero_ability_a: assert property (
    rd_st |-> ##2 reg_rdata[15:13] == 3'h0 && reg_rdata[11:6] == 6'h00)
    else $error("ability bits set");
  fixed_ones_a: assert property (
    rd_st |-> ##2 reg_rdata[12] && reg_rdata[0]) else $error("fixed ones");
  an_done_a: assert property (
    rd_st |-> ##2 reg_rdata[5] == $past(autoneg_done_internal
    && link_state_internal, 2)) else $error("autoneg done bit");
  autoneg_ability_internal_a: assert property (
    rd_st |-> ##2 reg_rdata[3] == $past(autoneg_ability_internal, 2))
    else $error("autoneg ability bit");
  no_faults_a: assert property (
    rd_st |-> ##2 !reg_rdata[4] && !reg_rdata[1]) else $error("fault bit");
  link_low_a: assert property (
    rd_st && !link_state_internal |-> ##2 !reg_rdata[2])
    else $error("link bit high while down");
  ind_write_a: assert property (
    reg_wr && reg_addr == 5'h0e && ctl_q[15:14] != 2'b00 |=> mmd_wr
    && mmd_wdata == $past(reg_wdata) && mmd_dev == ctl_q[4:0])
    else $error("indirect write lost");
  ind_read_a: assert property (
    rd_ie && ctl_q[15:14] != 2'b00 |=> mmd_rd && mmd_dev == ctl_q[4:0])
    else $error("indirect read lost");
  addr_mode_a: assert property (
    (rd_ie || reg_wr && reg_addr == 5'h0e) && ctl_q[15:14] == 2'b00
    |=> !mmd_rd && !mmd_wr) else $error("address mode reached device");
endmodule
bind c22_regs c22_regs_sva u_c22_regs_sva (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .autoneg_done_internal(autoneg_done_internal),
  .autoneg_ability_internal(autoneg_ability_internal),
  .link_state_internal(link_state_internal), .mmd_dev(mmd_dev),
  .mmd_addr(mmd_addr), .mmd_wr(mmd_wr), .mmd_rd(mmd_rd),
  .mmd_wdata(mmd_wdata), .mmd_rdata(mmd_rdata));
`default_nettype wire

//--- test/c22_mmd_model.sv
`timescale 1ns/1ps
`default_nettype none
module c22_mmd_model (
  // device-space port
  input  wire logic        clk,
  input  wire logic [4:0]  mmd_dev,
  input  wire logic [15:0] mmd_addr,
  input  wire logic        mmd_wr,
  input  wire logic        mmd_rd,
  input  wire logic [15:0] mmd_wdata,
  output logic      [15:0] mmd_rdata
);
  logic [15:0] mem [256];
  logic [15:0] last_q = 16'h0000;
  logic [7:0]  key;
  // small space: dev low bits and addr low bits only
  assign key = {mmd_dev[2:0], mmd_addr[4:0]};
  always @(posedge clk) begin
    if (mmd_wr)
      mem[key] <= mmd_wdata;
    if (mmd_rd)
      last_q <= mem[key];
  end
  // data only good in the read cycle; inverted otherwise
  assign mmd_rdata = mmd_rd ? mem[key] : ~last_q;
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        done = 1'b0;
  logic        able = 1'b1;
  logic        link = 1'b0;
  logic [4:0]  mdev;
  logic [15:0] maddr, mwdata, mrdata;
  logic        mwr, mrd;
  int          n_errors = 0;
  int          total_checks = 0;
  initial forever #12.5 clk = ~clk;
  c22_regs u_c22_regs (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .autoneg_done_internal(done), .autoneg_ability_internal(able),
    .link_state_internal(link), .mmd_dev(mdev), .mmd_addr(maddr),
    .mmd_wr(mwr), .mmd_rd(mrd), .mmd_wdata(mwdata), .mmd_rdata(mrdata));
  c22_mmd_model u_c22_mmd_model (.clk(clk), .mmd_dev(mdev),
    .mmd_addr(maddr), .mmd_wr(mwr), .mmd_rd(mrd), .mmd_wdata(mwdata),
    .mmd_rdata(mrdata));
  // ---------------------------------------------
  // register access tasks
  // ---------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] got;
    int          nv = 0;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    repeat (3) begin
      @(posedge clk);
      if (reg_rvalid === 1'b1) begin
        got = reg_rdata;
        nv++;
      end
    end
    total_checks++;
    // answer must be a single one-cycle pulse
    if (got !== exp || nv != 1) begin
      n_errors++;
      $display("CHECK FAILED %0t addr %h got %h exp %h", $time, a, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rc(5'h01, 16'h1009);
    link <= 1'b1;
    done <= 1'b1;
    rc(5'h01, 16'h1029);
    rc(5'h01, 16'h102d);
    @(posedge clk);
    link <= 1'b0;
    @(posedge clk);
    link <= 1'b1;
    rc(5'h01, 16'h1029);
    able <= 1'b0;
    rc(5'h01, 16'h1025);
    able <= 1'b1;
    done <= 1'b0;
    rc(5'h01, 16'h100d);
    wr(5'h02, 16'hffff);
    rc(5'h02, c22_pkg::ID_HIGH_VALUE);
    wr(5'h03, 16'h0000);
    rc(5'h03, {c22_pkg::ID_LOW_OUI, c22_pkg::ID_MODEL,
               c22_pkg::ID_REVISION});
    rc(5'h05, 16'h0000);
    rc(5'h0d, c22_pkg::IND_CTRL_RESET);
    wr(5'h0d, 16'hffff);
    rc(5'h0d, 16'hc01f);
    wr(5'h0d, 16'h0003);
    wr(5'h0e, 16'h0010);
    rc(5'h0e, 16'h0010);
    wr(5'h0d, 16'h4003);
    wr(5'h0e, 16'hbeef);
    rc(5'h0e, 16'hbeef);
    wr(5'h0d, 16'h0003);
    rc(5'h0e, 16'h0010);
    wr(5'h0d, 16'hc003);
    wr(5'h0e, 16'h1111);
    wr(5'h0e, 16'h2222);
    wr(5'h0d, 16'h0003);
    rc(5'h0e, 16'h0012);
    wr(5'h0e, 16'h0010);
    wr(5'h0d, 16'hc003);
    rc(5'h0e, 16'h1111);
    rc(5'h0e, 16'h1111);
    wr(5'h0d, 16'h8003);
    rc(5'h0e, 16'h1111);
    rc(5'h0e, 16'h2222);
    wr(5'h0d, 16'h0003);
    rc(5'h0e, 16'h0012);
    wr(5'h0d, 16'h0007);
    wr(5'h0e, 16'h0010);
    wr(5'h0d, 16'h4007);
    wr(5'h0e, 16'h7777);
    rc(5'h0e, 16'h7777);
    wr(5'h0d, 16'h0003);
    rc(5'h0e, 16'h0012);
    wr(5'h0e, 16'h0010);
    wr(5'h0d, 16'h4003);
    rc(5'h0e, 16'h1111);
    complete_run;
  end
endmodule
`default_nettype wire
